// ---- shared/hpt_pkg.sv ----
// Shared constants and types for the host port block.
package hpt_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int HPT_DATA_W = 32;
    localparam int HPT_ADDR_W = 8;
    localparam int HPT_LANES = 4;
    localparam int HPT_LANE_W = 8;
    localparam int HPT_LEVEL_W = 8;
    localparam int HPT_IRQ_W = 8;

    // ****************************************************************
    // Address map
    // ****************************************************************
    // Word addresses below this bound reach the data FIFOs in normal mode.
    localparam logic [HPT_ADDR_W-1:0] HPT_FIFO_WIN_END = 8'h10;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [HPT_LEVEL_W-1:0] HPT_LEVEL_RST = 8'h00;
    localparam logic [HPT_LEVEL_W-1:0] HPT_LEVEL_MAX = 8'hFF;
    localparam logic [HPT_LEVEL_W-1:0] HPT_LEVEL_ONE = 8'h01;
    localparam logic [HPT_DATA_W-1:0] HPT_DATA_RST = 32'h0000_0000;
    localparam logic [HPT_ADDR_W-1:0] HPT_ADDR_RST = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int HPT_CLK_PERIOD_NS = 100;
    localparam int HPT_TX_LEVEL_NS = 135;
    // A longest time rounds down, but never below one cycle.
    localparam int HPT_TX_LEVEL_CYC =
        (HPT_TX_LEVEL_NS / HPT_CLK_PERIOD_NS) < 1 ? 1 :
        (HPT_TX_LEVEL_NS / HPT_CLK_PERIOD_NS);

    // ****************************************************************
    // Cycle tracker states
    // ****************************************************************
    typedef enum logic [1:0] {
        HPT_IDLE  = 2'h0,
        HPT_READ  = 2'h1,
        HPT_SKIP  = 2'h3,
        HPT_WRITE = 2'h2
    } hpt_state_e;

    // Normal-mode decode: does this word address hit a data FIFO.
    function automatic logic hpt_is_fifo_addr(
        input logic [HPT_ADDR_W-1:0] addr
    );
        return addr < HPT_FIFO_WIN_END;
    endfunction

endpackage

// ---- core/hpt_lane_swap.sv ----
// Byte lane reorder between host order and internal little endian order.
`timescale 1ns/1ps
module hpt_lane_swap
    import hpt_pkg::*;
(
    input wire logic big_endian, // High selects reversed lanes
    input wire logic [HPT_DATA_W-1:0] din, // Word in
    output logic [HPT_DATA_W-1:0] dout // Word out
);

    // ****************************************************************
    // Lanes
    // ****************************************************************
    // The mapping is its own inverse, so one module serves both ways.
    for (genvar i = 0; i < HPT_LANES; i++) begin : g_lane
        assign dout[i*HPT_LANE_W +: HPT_LANE_W] = big_endian ?
            din[(HPT_LANES-1-i)*HPT_LANE_W +: HPT_LANE_W] :
            din[i*HPT_LANE_W +: HPT_LANE_W];
    end

endmodule

// ---- core/hpt_host_port.sv ----
// SRAM-like host port: cycle tracking, FIFO steering, endian reorder.
//
// Behaviour
// - Direct-FIFO pin: writes to TX, reads from RX.
// - Default mode decodes address to registers or FIFOs.
// - Endian pin low little, high big, per access.
// - Reorder four byte lanes to internal little endian.
// - Ordering chosen independently on every access.
// - Read active at reset release is ignored.
// - Writes discarded after reset until one read.
// - TX level updates within 135 ns of write.
// - Single reads and writes ended by either strobe.
// - Burst reads, including direct RX FIFO bursts.
// - Interrupt sources maskable, enabled ones drive request.
`timescale 1ns/1ps
module hpt_host_port
    import hpt_pkg::*;
(
    input wire logic clk_sys, // System clock, 10 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic chip_select_n, // Host chip select
    input wire logic read_strobe_n, // Host read strobe
    input wire logic write_strobe_n, // Host write strobe
    input wire logic [HPT_ADDR_W-1:0] host_addr, // Host word address
    input wire logic fifo_sel, // Direct-FIFO mode select
    input wire logic end_sel, // Endian select, high is big
    input wire logic [HPT_DATA_W-1:0] host_data_in, // Host data pins in
    output logic [HPT_DATA_W-1:0] host_data_out, // Host data pins out
    output logic host_data_oe, // Data pins driven
    output logic [HPT_ADDR_W-1:0] reg_addr, // Register address
    output logic reg_wr, // Register write pulse
    output logic reg_rd, // Register read pulse
    output logic [HPT_DATA_W-1:0] reg_wdata, // Register write data
    input wire logic [HPT_DATA_W-1:0] reg_rdata, // Register read data
    output logic tx_fifo_wr, // TX data FIFO push
    output logic [HPT_DATA_W-1:0] tx_fifo_wdata, // TX data FIFO word
    input wire logic tx_fifo_pop, // TX data FIFO drained a word
    output logic rx_fifo_rd, // RX data FIFO pop
    input wire logic [HPT_DATA_W-1:0] rx_fifo_rdata, // RX data FIFO word
    output logic [HPT_LEVEL_W-1:0] tx_fifo_level_info, // TX level
    input wire logic [HPT_IRQ_W-1:0] int_src, // Interrupt sources
    input wire logic [HPT_IRQ_W-1:0] int_en, // Interrupt enables
    output logic [HPT_IRQ_W-1:0] int_pending, // Enabled sources
    output logic irq // Interrupt request
);

    // ****************************************************************
    // Cycle tracker state
    // ****************************************************************
    hpt_state_e state_ff, nxt_state;
    logic [HPT_ADDR_W-1:0] addr_ff, nxt_addr;
    logic big_ff, nxt_big;
    logic fsel_ff, nxt_fsel;
    logic [HPT_DATA_W-1:0] hdata_ff, nxt_hdata;
    logic wr_go_ff, nxt_wr_go;
    logic rd_go_ff, nxt_rd_go;
    logic unlock_ff, nxt_unlock;
    logic [HPT_DATA_W-1:0] dout_ff, nxt_dout;
    logic [HPT_LEVEL_W-1:0] level_ff, nxt_level;
    logic irq_ff, nxt_irq;

    logic acc_rd;
    logic acc_wr;
    logic acc_any;
    logic to_fifo;
    logic [HPT_DATA_W-1:0] rd_word;
    logic [HPT_DATA_W-1:0] rd_host;
    logic [HPT_DATA_W-1:0] wr_int;

    // Either strobe may end a cycle: both must be low for it to be live.
    assign acc_rd = !chip_select_n && !read_strobe_n;
    assign acc_wr = !chip_select_n && !write_strobe_n;
    assign acc_any = acc_rd || acc_wr;

    // The mode and lane order are those latched at the cycle's start.
    assign to_fifo = fsel_ff || hpt_is_fifo_addr(addr_ff);

    // ****************************************************************
    // Lane reorder
    // ****************************************************************
    hpt_lane_swap u_swap_wr (
        .big_endian (big_ff),
        .din (hdata_ff),
        .dout (wr_int)
    );

    assign rd_word = to_fifo ? rx_fifo_rdata : reg_rdata;

    hpt_lane_swap u_swap_rd (
        .big_endian (big_ff),
        .din (rd_word),
        .dout (rd_host)
    );

    // ****************************************************************
    // Cycle tracker
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        nxt_big = big_ff;
        nxt_fsel = fsel_ff;
        nxt_hdata = hdata_ff;
        nxt_wr_go = 1'b0;
        nxt_rd_go = 1'b0;
        nxt_unlock = unlock_ff;
        nxt_dout = dout_ff;
        if (rd_go_ff) begin
            nxt_dout = rd_host;
        end
        unique case (state_ff)
            HPT_IDLE: begin
                if (acc_rd || acc_wr) begin
                    nxt_addr = host_addr;
                    nxt_big = end_sel;
                    nxt_fsel = fifo_sel;
                end
                if (acc_rd) begin
                    nxt_state = HPT_READ;
                    nxt_rd_go = 1'b1;
                end else if (acc_wr) begin
                    nxt_state = HPT_WRITE;
                    nxt_hdata = host_data_in;
                end
            end
            HPT_READ: begin
                if (!acc_rd) begin
                    nxt_state = HPT_IDLE;
                    nxt_unlock = 1'b1;
                end
            end
            HPT_WRITE: begin
                if (acc_wr) begin
                    nxt_hdata = host_data_in;
                end else begin
                    // Data is taken at the trailing edge, like an SRAM.
                    nxt_state = HPT_IDLE;
                    nxt_wr_go = unlock_ff;
                end
            end
            HPT_SKIP: begin
                // A cycle already running at reset release is let run out.
                if (!acc_any) begin
                    nxt_state = HPT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= HPT_SKIP;
            addr_ff <= HPT_ADDR_RST;
            big_ff <= 1'b0;
            fsel_ff <= 1'b0;
            hdata_ff <= HPT_DATA_RST;
            wr_go_ff <= 1'b0;
            rd_go_ff <= 1'b0;
            unlock_ff <= 1'b0;
            dout_ff <= HPT_DATA_RST;
        end else begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            big_ff <= nxt_big;
            fsel_ff <= nxt_fsel;
            hdata_ff <= nxt_hdata;
            wr_go_ff <= nxt_wr_go;
            rd_go_ff <= nxt_rd_go;
            unlock_ff <= nxt_unlock;
            dout_ff <= nxt_dout;
        end
    end

    assign reg_addr = addr_ff;
    assign reg_wr = wr_go_ff && !to_fifo;
    assign tx_fifo_wr = wr_go_ff && to_fifo;
    assign reg_rd = rd_go_ff && !to_fifo;
    assign rx_fifo_rd = rd_go_ff && to_fifo;
    assign reg_wdata = wr_int;
    assign tx_fifo_wdata = wr_int;
    assign host_data_out = dout_ff;
    assign host_data_oe = (state_ff == HPT_READ);

    // ****************************************************************
    // TX level and interrupt request
    // ****************************************************************
    // Level moves on the cycle after the push, well inside the limit.
    always_comb begin
        nxt_level = level_ff;
        if (tx_fifo_wr && !tx_fifo_pop && level_ff != HPT_LEVEL_MAX) begin
            nxt_level = level_ff + HPT_LEVEL_ONE;
        end else if (tx_fifo_pop && !tx_fifo_wr &&
                     level_ff != HPT_LEVEL_RST) begin
            nxt_level = level_ff - HPT_LEVEL_ONE;
        end
        nxt_irq = |(int_src & int_en);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            level_ff <= HPT_LEVEL_RST;
            irq_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
            irq_ff <= nxt_irq;
        end
    end

    assign tx_fifo_level_info = level_ff;
    assign int_pending = int_src & int_en;
    assign irq = irq_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    localparam int LVL_CYC = HPT_TX_LEVEL_CYC;

    sequence s_rd_start;
        state_ff == HPT_IDLE && acc_rd;
    endsequence

    sequence s_wr_end;
        state_ff == HPT_WRITE && !acc_wr && unlock_ff;
    endsequence

    sequence s_wr_start;
        state_ff == HPT_IDLE && acc_wr && !acc_rd;
    endsequence

    sequence s_rd_end;
        state_ff == HPT_READ && !acc_rd;
    endsequence

    a_fifo_write_steer: assert property (
        s_wr_end ##1 fsel_ff |-> tx_fifo_wr && !reg_wr)
        else $error("direct-FIFO write not steered to TX FIFO");

    a_fifo_read_steer: assert property (
        s_rd_start ##0 fifo_sel |=> rx_fifo_rd && !reg_rd)
        else $error("direct-FIFO read not served from RX FIFO");

    a_normal_decode: assert property (
        reg_wr || reg_rd |-> !fsel_ff && !hpt_is_fifo_addr(addr_ff))
        else $error("register access hit FIFO window");

    a_endian_sample: assert property (
        s_rd_start |=> big_ff == $past(end_sel) && state_ff == HPT_READ)
        else $error("endian select not sampled at access start");

    a_lane_swap: assert property (
        tx_fifo_wr && big_ff |->
            tx_fifo_wdata[HPT_LANE_W-1:0] ==
            hdata_ff[HPT_DATA_W-1 -: HPT_LANE_W])
        else $error("big endian lane order wrong");

    a_read_data_path: assert property (
        s_rd_start |=> rd_go_ff ##1 host_data_out == $past(rd_host))
        else $error("read data not returned two cycles after start");

    a_stale_read_skip: assert property (
        state_ff == HPT_SKIP |-> !host_data_oe && !reg_rd && !rx_fifo_rd)
        else $error("stale read cycle served after reset");

    a_write_locked: assert property (
        !unlock_ff |=> !reg_wr && !tx_fifo_wr)
        else $error("write taken before first read after reset");

    a_tx_level_time: assert property (
        tx_fifo_wr && !tx_fifo_pop && level_ff != HPT_LEVEL_MAX |->
            ##[1:LVL_CYC] level_ff == $past(level_ff) + HPT_LEVEL_ONE)
        else $error("TX level not updated in time");

    a_write_trailing: assert property (
        s_wr_end |=> wr_go_ff ##1 !wr_go_ff)
        else $error("write not committed once at its trailing edge");

    a_irq_mask: assert property (
        (int_src & int_en) == '0 |=> !irq)
        else $error("masked sources raised interrupt request");

    a_endian_write: assert property (
        s_wr_start |=> big_ff == $past(end_sel) && state_ff == HPT_WRITE)
        else $error("endian select not sampled at write start");

    a_little_straight: assert property (
        (reg_wr || tx_fifo_wr) && !big_ff |-> reg_wdata == hdata_ff)
        else $error("little endian lanes not passed straight");

    a_skip_exit: assert property (
        state_ff == HPT_SKIP && !acc_any |=> state_ff == HPT_IDLE)
        else $error("skip state not left once the bus went idle");

    a_read_unlock: assert property (
        s_rd_end |=> unlock_ff && state_ff == HPT_IDLE)
        else $error("completed read did not unlock writes");

    a_read_pulse_once: assert property (
        s_rd_start |=> (reg_rd || rx_fifo_rd) ##1 !(reg_rd || rx_fifo_rd))
        else $error("read pulse not exactly one cycle");

    a_level_hold: assert property (
        !tx_fifo_wr && !tx_fifo_pop |=> level_ff == $past(level_ff))
        else $error("TX level moved without push or pop");

endmodule

// ---- sim/hpt_host_model.sv ----
// Host bus master model that drives the SRAM-like strobes.
`timescale 1ns/1ps
module hpt_host_model
    import hpt_pkg::*;
(
    input wire logic clk_sys, // Bus clock
    input wire logic [HPT_DATA_W-1:0] data_rd, // Read data pins
    output logic cs_n = 1'b1, // Chip select
    output logic rd_n = 1'b1, // Read strobe
    output logic wr_n = 1'b1, // Write strobe
    output logic [HPT_ADDR_W-1:0] addr = 8'h00, // Word address
    output logic fs = 1'b0, // Direct-FIFO select
    output logic es = 1'b0, // Endian select
    output logic [HPT_DATA_W-1:0] data_wr = 32'h0 // Write data pins
);
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Every task starts after an edge, so at least two idle edges separate accesses.
    task automatic live(input logic v);
        @(posedge clk_sys);
        cs_n <= !v;
        rd_n <= !v;
    endtask

    task automatic rd(input logic [HPT_ADDR_W-1:0] a, input logic f, e, c,
                      output logic [HPT_DATA_W-1:0] d);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= a;
        fs <= f;
        es <= e;
        repeat (3) @(posedge clk_sys);
        d = data_rd;
        // A strobe-ended read leaves select low, so reads chain as a burst.
        if (c) begin
            rd_n <= 1'b1;
        end else begin
            cs_n <= 1'b1;
        end
        @(posedge clk_sys);
        rd_n <= 1'b1;
    endtask

    task automatic wr(input logic [HPT_ADDR_W-1:0] a, input logic f, e, c,
                      input logic [HPT_DATA_W-1:0] d);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        addr <= a;
        fs <= f;
        es <= e;
        data_wr <= d;
        repeat (2) @(posedge clk_sys);
        if (c) begin
            wr_n <= 1'b1;
        end else begin
            cs_n <= 1'b1;
        end
        @(posedge clk_sys);
        wr_n <= 1'b1;
        cs_n <= 1'b1;
        // A released bus must not keep showing the last word.
        data_wr <= ~d;
        // Two idle edges outlast every write-to-read wait at this clock,
        // so no dummy test register reads are needed.
        repeat (2) @(posedge clk_sys);
    endtask
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the host port block.
`timescale 1ns/1ps
module testbench;
    import hpt_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic cs_n, rd_n, wr_n, fs, es, oe, reg_wr, reg_rd, tx_wr, rx_rd, irq;
    logic pop = 1'b0;
    logic [HPT_ADDR_W-1:0] addr, reg_addr;
    logic [HPT_DATA_W-1:0] din, dout, reg_wdata, tx_wdata, cap, got, bus;
    logic [HPT_DATA_W-1:0] reg_rdata = 32'h0;
    logic [HPT_DATA_W-1:0] rx_rdata = 32'h0;
    logic [HPT_LEVEL_W-1:0] lvl, exp_lvl;
    logic [HPT_IRQ_W-1:0] src = 8'h00;
    logic [HPT_IRQ_W-1:0] en = 8'h00;
    logic [HPT_IRQ_W-1:0] pend;
    int miscompares = 0;
    int comparisons = 0;
    int seed = 32'h076F;
    int n_rr, n_rx, n_rw, n_tw, n_oe;
    int b_rr, b_rx, b_rw, b_tw, b_oe, n_x;
    logic [31:0] k;

    always #50 clk_sys = ~clk_sys;

    // Undriven pins show the inverse of the last word, so a late sample fails.
    assign bus = oe ? dout : ~dout;

    hpt_host_model host (.clk_sys(clk_sys), .data_rd(bus), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .fs(fs), .es(es),
        .data_wr(din));

    hpt_host_port dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .host_addr(addr), .fifo_sel(fs), .end_sel(es), .host_data_in(din),
        .host_data_out(dout), .host_data_oe(oe), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .tx_fifo_wr(tx_wr), .tx_fifo_wdata(tx_wdata),
        .tx_fifo_pop(pop), .rx_fifo_rd(rx_rd), .rx_fifo_rdata(rx_rdata),
        .tx_fifo_level_info(lvl), .int_src(src), .int_en(en),
        .int_pending(pend), .irq(irq));

    // ****************************************************************
    // Monitor and helpers
    // ****************************************************************
    always @(negedge clk_sys) begin
        n_rr += int'(reg_rd);
        n_rx += int'(rx_rd);
        n_rw += int'(reg_wr);
        n_tw += int'(tx_wr);
        n_oe += int'(oe);
        n_x += int'($isunknown({reg_rd, rx_rd, reg_wr, tx_wr, oe}));
        if (reg_wr === 1'b1) begin
            cap = reg_wdata;
        end
        if (tx_wr === 1'b1) begin
            cap = tx_wdata;
        end
    end

    function automatic logic [31:0] sw(logic [31:0] d, logic b);
        return b ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, want, seen);
        end
    endtask

    task automatic clr();
        b_rr = n_rr;
        b_rx = n_rx;
        b_rw = n_rw;
        b_tw = n_tw;
        b_oe = n_oe;
    endtask

    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Operations
    // ****************************************************************
    task automatic rd_op(logic [7:0] a, logic f, e, c);
        logic fifo;
        logic [31:0] v;
        logic [31:0] want;
        fifo = f || (a < HPT_FIFO_WIN_END);
        v = $random(seed);
        reg_rdata <= v;
        rx_rdata <= ~v;
        want = sw(fifo ? ~v : v, e);
        clr();
        host.rd(a, f, e, c, got);
        chk("read data", got, want);
        chk("rx pops", n_rx - b_rx, fifo);
        chk("reg reads", n_rr - b_rr, !fifo);
        chk("reg addr", reg_addr, a);
        // Strobes are seen low at three edges: three driven cycles.
        chk("oe cycles", n_oe - b_oe, 3);
    endtask

    task automatic wr_op(logic [7:0] a, logic f, e, c);
        logic fifo;
        logic [31:0] d;
        fifo = f || (a < HPT_FIFO_WIN_END);
        d = $random(seed);
        clr();
        host.wr(a, f, e, c, d);
        if (fifo && exp_lvl != HPT_LEVEL_MAX) begin
            exp_lvl++;
        end
        chk("tx pushes", n_tw - b_tw, fifo);
        chk("reg writes", n_rw - b_rw, !fifo);
        chk("write data", cap, sw(d, e));
        chk("write addr", reg_addr, a);
        chk("oe in write", n_oe - b_oe, 0);
        chk("tx level", lvl, exp_lvl);
    endtask

    task automatic misc_op();
        src <= $random(seed);
        en <= $random(seed);
        pop <= ($random(seed) & 3) == 0;
        @(posedge clk_sys);
        pop <= 1'b0;
        if (pop && exp_lvl != 0) begin
            exp_lvl--;
        end
        @(negedge clk_sys);
        chk("pending", pend, src & en);
        chk("irq", irq, |(src & en));
        chk("level after pop", lvl, exp_lvl);
    endtask

    // A read is held live across the release of reset on purpose.
    task automatic do_reset();
        arst_n <= 1'b0;
        host.live(1'b1);
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        clr();
        repeat (2) @(posedge clk_sys);
        host.live(1'b0);
        repeat (2) @(posedge clk_sys);
        chk("read pulses", n_rr + n_rx - b_rr - b_rx, 0);
        chk("oe at release", n_oe - b_oe, 0);
        exp_lvl = HPT_LEVEL_RST;
        clr();
        host.wr(8'h05, 1'b0, 1'b0, 1'b0, 32'hA5A5_5A5A);
        chk("locked writes", n_rw + n_tw - b_rw - b_tw, 0);
        chk("locked level", lvl, exp_lvl);
        rd_op(8'h24, 1'b0, 1'b1, 1'b0);
    endtask

    initial begin
        do_reset();
        for (int i = 0; i < 4; i++) begin
            rd_op(8'h40, 1'b1, i[0], 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            wr_op(8'h0F + 8'(i), i[1], i[0], i[1]);
        end
        for (int i = 0; i < 80; i++) begin
            k = $random(seed);
            case (k[1:0])
                2'h0: rd_op(k[15:8], k[2], k[3], k[4]);
                2'h1: wr_op(k[15:8], k[2], k[3], k[4]);
                default: misc_op();
            endcase
        end
        do_reset();
        wr_op(8'h03, 1'b0, 1'b1, 1'b1);
        chk("unknown strobes", n_x, 0);
        conclude();
    end

    initial begin
        #(100 * 20000);
        miscompares++;
        conclude();
    end
endmodule
